// File: pkg/ssmgt_pkg.sv
package ssmgt_pkg;
   // clock and millisecond tick timing
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned GAP_STEP_MS = 1;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned MS_CYCLES = (GAP_STEP_MS * NS_PER_MS) / CLK_PERIOD_NS;
   // 3.5 character times, counted as half-character ticks
   localparam logic [3:0] GAP_HALF_CHARS = 4'h7;
   // settings table word addresses
   localparam logic [7:0] ADR_P1_GAP = 8'h06;
   localparam logic [7:0] ADR_P1_IN = 8'h07;
   localparam logic [7:0] ADR_P1_OUT = 8'h08;
   localparam logic [7:0] ADR_P1_HOLD = 8'h09;
   localparam logic [7:0] ADR_P2_GAP = 8'h10;
   localparam logic [7:0] ADR_P2_IN = 8'h11;
   localparam logic [7:0] ADR_P2_OUT = 8'h12;
   localparam logic [7:0] ADR_P2_HOLD = 8'h13;
   // field one-hot positions returned by the address decoder
   localparam int unsigned FLD_GAP = 0;
   localparam int unsigned FLD_IN = 1;
   localparam int unsigned FLD_OUT = 2;
   localparam int unsigned FLD_HOLD = 3;
   // shared data space
   localparam logic [16:0] DATA_WORDS = 17'h00fa0;
   localparam logic [15:0] MAX_OFFSET = 16'h0f9f;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // function codes
   localparam logic [7:0] FC_RD_COILS = 8'h01;
   localparam logic [7:0] FC_RD_DISC = 8'h02;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INREG = 8'h04;
   localparam logic [7:0] FC_WR_COIL = 8'h05;
   localparam logic [7:0] FC_WR_REG = 8'h06;
   localparam logic [7:0] FC_WR_COILS = 8'h0f;
   localparam logic [7:0] FC_WR_REGS = 8'h10;

   typedef enum logic [3:0] {
      SEL_NONE = 4'b0001,
      SEL_IN = 4'b0010,
      SEL_OUT = 4'b0100,
      SEL_HOLD = 4'b1000
   } ssmgt_sel_t;

   typedef struct packed {
      logic [15:0] gap_ext;
      logic [15:0] in_base;
      logic [15:0] out_base;
      logic [15:0] hold_base;
   } ssmgt_port_cfg_t;

   typedef struct packed {
      logic port;
      logic [7:0] func;
      logic [15:0] addr;
   } ssmgt_req_t;

   typedef struct packed {
      logic ok;
      logic [11:0] word;
   } ssmgt_map_t;
endpackage

// File: verilog/ssmgt_gap_timer.sv
`timescale 1ns/10ps
module ssmgt_gap_timer
   import ssmgt_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   input wire logic ms_tick, // 1 ms enable pulse
   input wire logic half_tick, // half character time pulse
   input wire logic rx_busy, // line activity
   input wire logic [15:0] ext, // idle gap extension in ms
   output logic done // request complete pulse
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_GAP = 2'b10
   } ssmgt_tst_t;

   ssmgt_tst_t state_r, state_nxt;
   logic [3:0] half_r, half_nxt;
   logic [15:0] ms_r, ms_nxt;
   logic done_r, done_nxt;

   // activity restarts both counts; both must expire before completion
   always_comb begin
      state_nxt = state_r;
      half_nxt = half_r;
      ms_nxt = ms_r;
      done_nxt = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            if (rx_busy) begin
               state_nxt = ST_GAP;
               half_nxt = 4'h0;
               ms_nxt = 16'h0000;
            end
         end
         ST_GAP: begin
            if (rx_busy) begin
               half_nxt = 4'h0;
               ms_nxt = 16'h0000;
            end else if (half_r == GAP_HALF_CHARS && ms_r >= ext) begin
               done_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end else begin
               if (half_tick && half_r != GAP_HALF_CHARS) half_nxt = half_r + 4'h1;
               if (ms_tick && ms_r < ext) ms_nxt = ms_r + 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         half_r <= 4'h0;
         ms_r <= 16'h0000;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         half_r <= half_nxt;
         ms_r <= ms_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_done_cause;
      done_r |-> $past(state_r == ST_GAP && !rx_busy && half_r == GAP_HALF_CHARS && ms_r >= ext);
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("completion without full gap");

   property p_busy_restarts;
      (state_r == ST_GAP && rx_busy) |=> (half_r == 4'h0 && ms_r == 16'h0000 && !done_r);
   endproperty
   a_busy_restarts: assert property (p_busy_restarts) else $error("activity did not restart gap");

   // host may lower the extension mid-gap, so only each step is bounded
   property p_ms_bounded;
      (state_r == ST_GAP && ms_r != $past(ms_r)) |-> (ms_r == 16'h0000 || ms_r <= $past(ext));
   endproperty
   a_ms_bounded: assert property (p_ms_bounded) else $error("ms count beyond extension");

   property p_done_one_cycle;
      done_r |-> (state_r == ST_IDLE) ##1 !done_r;
   endproperty
   a_done_one_cycle: assert property (p_done_one_cycle) else $error("done not a single pulse");
endmodule

// File: verilog/ssmgt_top.sv
`timescale 1ns/10ps
// Functional notes
// - by default a request completes after 3.5 idle character times
// - extension setting gives idle milliseconds also required, timed alongside the 3.5 character times, before accepting a request
// - extension setting is unsigned, 0 to 65535 ms
// - in master operation the three base offsets of that port are ignored
// - functions 2 and 4 add the input base offset to the address
// - address zero of functions 2 or 4 maps exactly to the input base
// - functions 1, 5 and 15 add the output base offset
// - functions 3, 6 and 16 add the holding base offset
// - base offsets lie in a 4000-word space, values 0 to 3999
module ssmgt_top
   import ssmgt_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = MS_CYCLES // cycles per 1 ms tick
)
(
   input wire logic clk, // system clock, 50 MHz
   input wire logic rst, // async reset, high
   input wire logic cfg_wr, // settings write strobe
   input wire logic cfg_rd, // settings read strobe
   input wire logic [7:0] cfg_addr, // settings word address
   input wire logic [15:0] cfg_wdata, // settings write data
   output logic [15:0] cfg_rdata, // settings read data
   output logic cfg_err, // write refused pulse
   input wire logic [1:0] port_master, // port runs as master
   input wire logic [1:0] rx_busy, // per-port line activity
   input wire logic [1:0] half_tick, // per-port half char pulse
   output logic [1:0] frame_done, // per-port request complete
   input wire logic req_valid, // mapping request strobe
   input wire ssmgt_req_t req, // port, function, address
   output logic map_valid, // mapping result strobe
   output ssmgt_map_t map // ok flag and word offset
);
   ssmgt_port_cfg_t cfg_r [2];
   ssmgt_port_cfg_t cfg_nxt [2];
   logic [15:0] rdata_r, rdata_nxt;
   logic err_r, err_nxt;
   logic [15:0] ms_cnt_r, ms_cnt_nxt;
   logic ms_tick_r, ms_tick_nxt;
   logic map_valid_r, map_valid_nxt;
   ssmgt_map_t map_r, map_nxt;
   ssmgt_port_cfg_t req_cfg;
   ssmgt_sel_t req_sel;
   logic [15:0] req_base;
   logic [16:0] req_sum;
   logic [3:0] fld [2];

   // one-hot field hit for a given port
   function automatic logic [3:0] field_of(input logic [7:0] a, input logic p);
      logic [3:0] f;
      f = 4'h0;
      if (!p) begin
         f[FLD_GAP] = (a == ADR_P1_GAP);
         f[FLD_IN] = (a == ADR_P1_IN);
         f[FLD_OUT] = (a == ADR_P1_OUT);
         f[FLD_HOLD] = (a == ADR_P1_HOLD);
      end else begin
         f[FLD_GAP] = (a == ADR_P2_GAP);
         f[FLD_IN] = (a == ADR_P2_IN);
         f[FLD_OUT] = (a == ADR_P2_OUT);
         f[FLD_HOLD] = (a == ADR_P2_HOLD);
      end
      return f;
   endfunction

   // which base a function code uses
   function automatic ssmgt_sel_t base_sel(input logic [7:0] fc);
      ssmgt_sel_t s;
      s = SEL_NONE;
      if (fc == FC_RD_DISC || fc == FC_RD_INREG) s = SEL_IN;
      if (fc == FC_RD_COILS || fc == FC_WR_COIL || fc == FC_WR_COILS) s = SEL_OUT;
      if (fc == FC_RD_HOLD || fc == FC_WR_REG || fc == FC_WR_REGS) s = SEL_HOLD;
      return s;
   endfunction

   assign fld[0] = field_of(cfg_addr, 1'b0);
   assign fld[1] = field_of(cfg_addr, 1'b1);

   // settings writes; an out-of-range offset keeps the old value
   always_comb begin
      cfg_nxt = cfg_r;
      err_nxt = 1'b0;
      rdata_nxt = rdata_r;
      if (cfg_wr) begin
         if (fld[0] == 4'h0 && fld[1] == 4'h0) err_nxt = 1'b1;
         for (int p = 0; p < 2; p++) begin
            if (fld[p][FLD_GAP]) cfg_nxt[p].gap_ext = cfg_wdata;
            if (fld[p][FLD_GAP] == 1'b0 && fld[p] != 4'h0 && cfg_wdata > MAX_OFFSET) begin
               err_nxt = 1'b1;
            end else begin
               if (fld[p][FLD_IN]) cfg_nxt[p].in_base = cfg_wdata;
               if (fld[p][FLD_OUT]) cfg_nxt[p].out_base = cfg_wdata;
               if (fld[p][FLD_HOLD]) cfg_nxt[p].hold_base = cfg_wdata;
            end
         end
      end
      // unmapped reads return zero
      if (cfg_rd) begin
         rdata_nxt = 16'h0000;
         for (int p = 0; p < 2; p++) begin
            if (fld[p][FLD_GAP]) rdata_nxt = cfg_r[p].gap_ext;
            if (fld[p][FLD_IN]) rdata_nxt = cfg_r[p].in_base;
            if (fld[p][FLD_OUT]) rdata_nxt = cfg_r[p].out_base;
            if (fld[p][FLD_HOLD]) rdata_nxt = cfg_r[p].hold_base;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < 2; p++) begin
            cfg_r[p] <= {CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
         end
         rdata_r <= 16'h0000;
         err_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   // 1 ms enable shared by both ports, one counter instead of two
   always_comb begin
      ms_tick_nxt = 1'b0;
      ms_cnt_nxt = ms_cnt_r + 16'h0001;
      if (ms_cnt_r == 16'(MS_CYCLES_P - 1)) begin
         ms_cnt_nxt = 16'h0000;
         ms_tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ms_cnt_r <= 16'h0000;
         ms_tick_r <= 1'b0;
      end else begin
         ms_cnt_r <= ms_cnt_nxt;
         ms_tick_r <= ms_tick_nxt;
      end
   end

   // each port times its own gap from its own setting
   for (genvar g = 0; g < 2; g++) begin : g_port
      ssmgt_gap_timer u_gap (
         .clk(clk),
         .rst(rst),
         .ms_tick(ms_tick_r),
         .half_tick(half_tick[g]),
         .rx_busy(rx_busy[g]),
         .ext(cfg_r[g].gap_ext),
         .done(frame_done[g])
      );
   end

   // address mapping; sum kept 17 bits so overflow cannot wrap into range
   always_comb begin
      req_cfg = cfg_r[req.port];
      req_sel = base_sel(req.func);
      req_base = 16'h0000;
      unique case (req_sel)
         SEL_NONE: req_base = 16'h0000;
         SEL_IN: req_base = req_cfg.in_base;
         SEL_OUT: req_base = req_cfg.out_base;
         SEL_HOLD: req_base = req_cfg.hold_base;
      endcase
      req_sum = {1'b0, req_base} + {1'b0, req.addr};
      map_valid_nxt = req_valid;
      map_nxt = map_r;
      if (req_valid) begin
         map_nxt.ok = !port_master[req.port] && req_sel != SEL_NONE
                      && req_sum < DATA_WORDS;
         map_nxt.word = map_nxt.ok ? req_sum[11:0] : 12'h000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         map_valid_r <= 1'b0;
         map_r <= '0;
      end else begin
         map_valid_r <= map_valid_nxt;
         map_r <= map_nxt;
      end
   end

   assign cfg_rdata = rdata_r;
   assign cfg_err = err_r;
   assign map_valid = map_valid_r;
   assign map = map_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_in_req;
      req_valid && !port_master[req.port] && (req.func == FC_RD_DISC || req.func == FC_RD_INREG);
   endsequence

   property p_in_zero;
      (s_in_req and (req.addr == 16'h0000)) |=> (map_valid && map.ok
         && map.word == $past(cfg_r[req.port].in_base[11:0]));
   endproperty
   a_in_zero: assert property (p_in_zero) else $error("address zero not at input base");

   property p_in_sum;
      (s_in_req and ({1'b0, cfg_r[req.port].in_base} + {1'b0, req.addr} < DATA_WORDS))
         |=> map.ok && map.word == $past(cfg_r[req.port].in_base[11:0] + req.addr[11:0]);
   endproperty
   a_in_sum: assert property (p_in_sum) else $error("input mapping wrong");

   property p_out_map;
      (req_valid && !port_master[req.port] && req.func == FC_WR_COILS
         && req_sum < DATA_WORDS) |=> map.ok
         && map.word == $past(cfg_r[req.port].out_base[11:0] + req.addr[11:0]);
   endproperty
   a_out_map: assert property (p_out_map) else $error("coil mapping wrong");

   property p_hold_map;
      (req_valid && !port_master[req.port] && req.func == FC_WR_REGS && req.addr == 16'h0000)
         |=> map.ok && map.word == $past(cfg_r[req.port].hold_base[11:0]);
   endproperty
   a_hold_map: assert property (p_hold_map) else $error("holding mapping wrong");

   property p_master_ignored;
      (req_valid && port_master[req.port]) |=> (map_valid && !map.ok);
   endproperty
   a_master_ignored: assert property (p_master_ignored) else $error("master port mapped");

   property p_offset_range;
      (cfg_wr && cfg_addr == ADR_P1_IN && cfg_wdata > MAX_OFFSET)
         |=> (cfg_err && $stable(cfg_r[0].in_base));
   endproperty
   a_offset_range: assert property (p_offset_range) else $error("offset above 3999 taken");

   property p_port_separate;
      (cfg_wr && fld[0] != 4'h0) |=> $stable(cfg_r[1]);
   endproperty
   a_port_separate: assert property (p_port_separate) else $error("port 2 disturbed");

   property p_ms_spacing;
      ms_tick_r |=> (!ms_tick_r) [*2];
   endproperty
   a_ms_spacing: assert property (p_ms_spacing) else $error("ms tick too frequent");
endmodule

// File: test/ssmgt_master_model.sv
`timescale 1ns/10ps
// far-side serial master: frames on the line plus free running half char pulses
module ssmgt_master_model #(
   parameter int HALF_CYC = 4 // cycles per half character
)
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   output logic rx_busy, // line activity
   output logic half_tick // half character pulse
);
   logic [7:0] cnt_r;
   initial rx_busy = 1'b0;
   // baud divider runs free, so gap phase is not aligned to the frame end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 8'h00;
         half_tick <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == 8'(HALF_CYC - 1)) ? 8'h00 : cnt_r + 8'h01;
         half_tick <= (cnt_r == 8'(HALF_CYC - 1));
      end
   end
   // one request of n busy cycles, then the line goes idle; call at a rising edge
   task automatic send_frame(input int n);
      rx_busy <= 1'b1;
      repeat (n) @(posedge clk);
      rx_busy <= 1'b0;
   endtask
endmodule

// File: test/serial_slave_map_and_gap_timer_test.sv
`timescale 1ns/10ps
module serial_slave_map_and_gap_timer_test;
   import ssmgt_pkg::*;
   localparam int MS_C = 10;
   logic clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, req_valid = 1'b0, cfg_err, map_valid;
   logic [7:0] cfg_addr = 8'h00;
   logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, rd;
   logic [1:0] port_master = 2'b00, frame_done;
   wire logic [1:0] rx_busy, half_tick; // one bit from each far-side model
   ssmgt_req_t req = '0;
   ssmgt_map_t map;
   int n_mismatch = 0, cmp_count = 0;
   logic [7:0] adrs [8] = '{ADR_P1_GAP, ADR_P1_IN, ADR_P1_OUT, ADR_P1_HOLD,
                            ADR_P2_GAP, ADR_P2_IN, ADR_P2_OUT, ADR_P2_HOLD};
   logic [7:0] fcs [8] = '{FC_RD_COILS, FC_RD_DISC, FC_RD_HOLD, FC_RD_INREG,
                           FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS};
   // offsets per port: input, output, holding
   logic [15:0] bases [2][3] = '{'{16'h0096, 16'h0064, 16'h00c8}, '{16'h03e8, 16'h07d0, 16'h0bb8}};
   always #10 clk = ~clk;
   ssmgt_top #(.MS_CYCLES_P(MS_C)) dut_u (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_err(cfg_err),
      .port_master(port_master), .rx_busy(rx_busy), .half_tick(half_tick),
      .frame_done(frame_done), .req_valid(req_valid), .req(req), .map_valid(map_valid),
      .map(map));
   ssmgt_master_model m1_u (.clk(clk), .rst(rst), .rx_busy(rx_busy[0]), .half_tick(half_tick[0]));
   ssmgt_master_model m2_u (.clk(clk), .rst(rst), .rx_busy(rx_busy[1]), .half_tick(half_tick[1]));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one settings cycle; result sampled just after the taking edge
   task automatic cfg_op(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      cfg_wr <= wr;
      cfg_rd <= ~wr;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b0;
      #1 rd = cfg_rdata;
   endtask
   task automatic map_req(input logic p, input logic [7:0] f, input logic [15:0] a,
                          input logic ok, input logic [11:0] w);
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{port: p, func: f, addr: a};
      @(posedge clk);
      req_valid <= 1'b0;
      #1 check("map_valid", 32'(map_valid), 32'h1);
      check("map", 32'({map.ok, map.word}), 32'({ok, w}));
   endtask

   // reset values, readback, refused writes, separate copies per port
   task automatic t_settings;
      for (int i = 0; i < 8; i++) begin
         cfg_op(1'b0, adrs[i], 16'h0000);
         check("reset value", 32'(rd), 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
         cfg_op(1'b1, adrs[i], (i % 4 == 0) ? 16'hffff : 16'h0f9f - 16'(i));
         check("cfg_err on good write", 32'(cfg_err), 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
         cfg_op(1'b0, adrs[i], 16'h0000);
         check("readback", 32'(rd), (i % 4 == 0) ? 32'hffff : 32'h0f9f - 32'(i));
      end
      cfg_op(1'b1, ADR_P1_IN, 16'h0fa0);
      check("cfg_err on 4000", 32'(cfg_err), 32'h1);
      cfg_op(1'b0, ADR_P1_IN, 16'h0000);
      check("refused keeps value", 32'(rd), 32'h0f9e);
      cfg_op(1'b1, 8'h0a, 16'h1234);
      check("cfg_err unmapped", 32'(cfg_err), 32'h1);
      cfg_op(1'b0, 8'h0a, 16'h0000);
      check("unmapped read", 32'(rd), 32'h0);
      $display("test settings done");
   endtask

   // every function code on both ports, limits, bad code, master mode
   task automatic t_map;
      logic [15:0] b;
      for (int p = 0; p < 2; p++)
         for (int k = 0; k < 3; k++) cfg_op(1'b1, adrs[p * 4 + k + 1], bases[p][k]);
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 8; i++) begin
            // inputs for 2 and 4, outputs for 1/5/15, holding for 3/6/16
            b = (fcs[i] == FC_RD_DISC || fcs[i] == FC_RD_INREG) ? bases[p][0] :
                (fcs[i] == FC_RD_HOLD || fcs[i] == FC_WR_REG || fcs[i] == FC_WR_REGS) ?
                bases[p][2] : bases[p][1];
            map_req(p[0], fcs[i], 16'h0000, 1'b1, b[11:0]);
            map_req(p[0], fcs[i], 16'h0007, 1'b1, 12'(b + 16'h0007));
         end
      map_req(1'b1, FC_RD_HOLD, 16'h03e7, 1'b1, 12'hf9f);
      map_req(1'b1, FC_RD_HOLD, 16'h03e8, 1'b0, 12'h000);
      map_req(1'b0, 8'h07, 16'h0000, 1'b0, 12'h000);
      @(posedge clk);
      port_master <= 2'b01;
      map_req(1'b0, FC_RD_HOLD, 16'h0000, 1'b0, 12'h000);
      map_req(1'b1, FC_RD_HOLD, 16'h0000, 1'b1, 12'hbb8);
      @(posedge clk);
      port_master <= 2'b00;
      $display("test mapping done");
   endtask

   // cycles from line idle to frame_done must fall within the window
   task automatic gap_run(input int p, input int n_busy, input int lo, input int hi);
      int cnt;
      @(posedge clk);
      if (p == 0) m1_u.send_frame(n_busy);
      else m2_u.send_frame(n_busy);
      cnt = 0;
      do begin
         @(posedge clk);
         #1 cnt++;
      end while (frame_done[p] !== 1'b1 && cnt < 2000);
      if (cnt >= 2000) begin
         n_mismatch++;
         $display("MISMATCH frame_done timeout expected 1 seen 0");
         summarize();
      end
      check("gap window", 32'(cnt >= lo && cnt <= hi), 32'h1);
      @(posedge clk);
      #1 check("done one cycle", 32'(frame_done[p]), 32'h0);
   endtask

   // default gap, extension on one port only, activity on the other port not disturbing a gap
   task automatic t_gap;
      cfg_op(1'b1, ADR_P1_GAP, 16'h0000);
      cfg_op(1'b1, ADR_P2_GAP, 16'h0006);
      gap_run(0, 5, 24, 32);
      gap_run(1, 5, 50, 64);
      cfg_op(1'b1, ADR_P1_GAP, 16'h0003);
      gap_run(0, 3, 28, 34);
      fork
         gap_run(1, 3, 50, 64);
         begin
            repeat (20) @(posedge clk);
            m1_u.send_frame(2); // activity on the other port must not disturb this one
         end
      join
      $display("test gap timer done");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_settings();
      t_map();
      t_gap();
      summarize();
   end
endmodule
